// File: logic/fan_table_defines.vh
`ifndef FAN_TABLE_DEFINES_VH
`define FAN_TABLE_DEFINES_VH

// ----------------------------------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------------------------------
`define IDX_TBL_CTRL 8'h4a
`define IDX_TBL_OFFSET 8'h4e
`define IDX_E7_THR 8'h5c
`define IDX_E7_DUTY 8'h5d
`define IDX_E8_THR 8'h5e
`define IDX_E8_DUTY 8'h5f
`define IDX_TBL_MODE 8'h70
`define IDX_TBL_STATUS 8'h71

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define BIT_WR_UNLOCK 5
`define BIT_TEMP_HIRES 0
`define BIT_DUTY_HIRES 1
`define BIT_PWM_22K5 2
`define BIT_HALF 7
`define THR_WHOLE_MSB 6
`define DUTY_EXT_MSB 7
`define DUTY_EXT_LSB 6
`define DUTY_BASE_MSB 5
`define BIT_HIT7 0
`define BIT_HIT8 1

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define RST_THR 8'h7f
`define RST_DUTY 8'h3f
`define RST_CTRL 8'h00
`define RST_OFFSET 8'h00
`define RST_MODE 8'h00
`define RST_DUTY_OUT 8'h00

`endif

// File: logic/fan_table_entry.v
`timescale 1ns/100ps
`default_nettype none

`include "fan_table_defines.vh"

// ----------------------------------------------------------------
// One table entry: threshold compare and duty formation
// ----------------------------------------------------------------
module fan_table_entry (
    input wire [7:0] thr_raw,
    input wire [7:0] duty_raw,
    input wire [7:0] offset,
    input wire temp_hires,
    input wire duty_ext_en,
    input wire [10:0] remote_temp,
    output wire hit,
    output wire [7:0] thr_view,
    output wire [7:0] duty_view
);

    wire half_bit;
    wire [7:0] thr_halves;
    wire [9:0] thr_eff;
    wire [8:0] temp_halves;
    wire [1:0] duty_ext;

    // Half bit only counts in high resolution
    assign half_bit = temp_hires & thr_raw[`BIT_HALF];
    assign thr_view = {half_bit, thr_raw[`THR_WHOLE_MSB:0]};
    // Threshold in half degrees, always unsigned
    assign thr_halves = {thr_raw[`THR_WHOLE_MSB:0], half_bit};
    // Offset in whole degrees lifts the threshold past 127.5
    assign thr_eff = {2'b00, thr_halves} + {1'b0, offset, 1'b0};
    // Reading in 1/8 degree: 9 bits used high, 8 bits low
    assign temp_halves = temp_hires ? remote_temp[10:2] : {remote_temp[10:3], 1'b0};
    assign hit = ({1'b0, temp_halves} > thr_eff);
    assign duty_ext = duty_ext_en ? duty_raw[`DUTY_EXT_MSB:`DUTY_EXT_LSB] : 2'b00;
    assign duty_view = {duty_ext, duty_raw[`DUTY_BASE_MSB:0]};

endmodule // fan_table_entry

`default_nettype wire

// File: logic/fan_table_regs.v
// Notes on behaviour
// - Table writes ignored unless control bit 5 set
// - Low temperature resolution forces threshold bit 7 zero
// - High resolution adds half-degree bit 7 to threshold
// - Temperature above threshold selects entry's paired duty
// - Compare 9 reading bits high, 8 low
// - Thresholds are always positive, no sign bit
// - Offset register raises effective thresholds past 127.5
// - Low duty resolution forces duty bits 7:6 zero
// - High duty resolution uses bits 7:6 with 5:0
// - Extended duty bits need 22.5kHz PWM selection
//
// Decided for this implementation: register access over APB.
`timescale 1ns/100ps
`default_nettype none

`include "fan_table_defines.vh"

module fan_table_regs #(
    parameter ADDR_W = 10
) (
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [ADDR_W-1:0] paddr,
    input wire [31:0] pwdata,
    input wire [3:0] pstrb,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    input wire [10:0] remote_temp,
    output reg [7:0] fan_duty,
    output reg table_active
);

    // ----------------------------------------------------------------
    // Storage
    // ----------------------------------------------------------------
    reg [7:0] tbl_ctrl;
    reg [7:0] tbl_offset;
    reg [7:0] e7_thr;
    reg [7:0] e7_duty;
    reg [7:0] e8_thr;
    reg [7:0] e8_duty;
    reg [7:0] tbl_mode;
    reg [1:0] hit_state;

    // ----------------------------------------------------------------
    // Mode decode
    // ----------------------------------------------------------------
    wire temp_hires;
    wire duty_hires;
    wire pwm_22k5;
    wire duty_ext_en;
    wire table_unlocked;

    assign temp_hires = tbl_mode[`BIT_TEMP_HIRES];
    assign duty_hires = tbl_mode[`BIT_DUTY_HIRES];
    assign pwm_22k5 = tbl_mode[`BIT_PWM_22K5];
    // Extended duty bits only live at the fast PWM rate
    assign duty_ext_en = duty_hires & pwm_22k5;
    assign table_unlocked = tbl_ctrl[`BIT_WR_UNLOCK];

    // ----------------------------------------------------------------
    // Entries
    // ----------------------------------------------------------------
    wire hit7;
    wire hit8;
    wire [7:0] thr7_view;
    wire [7:0] thr8_view;
    wire [7:0] duty7_view;
    wire [7:0] duty8_view;

    fan_table_entry entry7 (
        .thr_raw(e7_thr),
        .duty_raw(e7_duty),
        .offset(tbl_offset),
        .temp_hires(temp_hires),
        .duty_ext_en(duty_ext_en),
        .remote_temp(remote_temp),
        .hit(hit7),
        .thr_view(thr7_view),
        .duty_view(duty7_view)
    );

    fan_table_entry entry8 (
        .thr_raw(e8_thr),
        .duty_raw(e8_duty),
        .offset(tbl_offset),
        .temp_hires(temp_hires),
        .duty_ext_en(duty_ext_en),
        .remote_temp(remote_temp),
        .hit(hit8),
        .thr_view(thr8_view),
        .duty_view(duty8_view)
    );

    // ----------------------------------------------------------------
    // Duty selection
    // ----------------------------------------------------------------
    reg [7:0] next_fan_duty;
    reg next_table_active;

    always @*
    begin
        next_fan_duty = fan_duty;
        next_table_active = 1'b0;
        if (hit8)
        begin
            // Higher entry takes priority
            next_fan_duty = duty8_view;
            next_table_active = 1'b1;
        end
        else if (hit7)
        begin
            next_fan_duty = duty7_view;
            next_table_active = 1'b1;
        end
    end

    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            fan_duty <= `RST_DUTY_OUT;
            table_active <= 1'b0;
            hit_state <= 2'b00;
        end
        else
        begin
            fan_duty <= next_fan_duty;
            table_active <= next_table_active;
            hit_state <= {hit8, hit7};
        end
    end

    // ----------------------------------------------------------------
    // APB decode
    // ----------------------------------------------------------------
    wire [7:0] word_idx;
    wire addr_aligned;
    wire setup_phase;
    wire write_now;
    wire wr_lane;
    reg mapped;
    reg is_table;
    reg [7:0] rd_byte;

    assign word_idx = paddr[9:2];
    assign addr_aligned = (paddr[1:0] == 2'b00);
    assign setup_phase = psel & ~penable;
    // Write lands on the completing access edge only
    assign write_now = psel & penable & pready & pwrite & ~pslverr;
    assign wr_lane = pstrb[0];

    always @*
    begin
        mapped = 1'b1;
        is_table = 1'b0;
        rd_byte = 8'h00;
        case (word_idx)
            `IDX_TBL_CTRL:
            begin
                rd_byte = tbl_ctrl;
            end
            `IDX_TBL_OFFSET:
            begin
                rd_byte = tbl_offset;
            end
            `IDX_E7_THR:
            begin
                is_table = 1'b1;
                rd_byte = thr7_view;
            end
            `IDX_E7_DUTY:
            begin
                is_table = 1'b1;
                rd_byte = duty7_view;
            end
            `IDX_E8_THR:
            begin
                is_table = 1'b1;
                rd_byte = thr8_view;
            end
            `IDX_E8_DUTY:
            begin
                is_table = 1'b1;
                rd_byte = duty8_view;
            end
            `IDX_TBL_MODE:
            begin
                rd_byte = tbl_mode;
            end
            `IDX_TBL_STATUS:
            begin
                rd_byte = {6'h00, hit_state};
            end
            default:
            begin
                mapped = 1'b0;
            end
        endcase
        if (!addr_aligned)
        begin
            mapped = 1'b0;
            rd_byte = 8'h00;
        end
    end

    // ----------------------------------------------------------------
    // APB response: one cycle after setup, from flip-flops
    // ----------------------------------------------------------------
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end
        else if (setup_phase)
        begin
            pready <= 1'b1;
            pslverr <= ~mapped;
            prdata <= pwrite ? 32'h0000_0000 : {24'h00_0000, rd_byte};
        end
        else
        begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end
    end

    // ----------------------------------------------------------------
    // Register writes
    // ----------------------------------------------------------------
    wire ctrl_wr;
    wire table_wr;

    assign ctrl_wr = write_now & wr_lane;
    // Locked table entries stay read-only, no error is flagged
    assign table_wr = ctrl_wr & is_table & table_unlocked;

    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            tbl_ctrl <= `RST_CTRL;
            tbl_offset <= `RST_OFFSET;
            tbl_mode <= `RST_MODE;
        end
        else if (ctrl_wr)
        begin
            if (word_idx == `IDX_TBL_CTRL)
            begin
                tbl_ctrl <= pwdata[7:0];
            end
            if (word_idx == `IDX_TBL_OFFSET)
            begin
                tbl_offset <= pwdata[7:0];
            end
            if (word_idx == `IDX_TBL_MODE)
            begin
                tbl_mode <= {5'h00, pwdata[2:0]};
            end
        end
    end

    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            e7_thr <= `RST_THR;
            e7_duty <= `RST_DUTY;
            e8_thr <= `RST_THR;
            e8_duty <= `RST_DUTY;
        end
        else if (table_wr)
        begin
            case (word_idx)
                `IDX_E7_THR:
                begin
                    e7_thr <= pwdata[7:0];
                end
                `IDX_E7_DUTY:
                begin
                    e7_duty <= pwdata[7:0];
                end
                `IDX_E8_THR:
                begin
                    e8_thr <= pwdata[7:0];
                end
                `IDX_E8_DUTY:
                begin
                    e8_duty <= pwdata[7:0];
                end
                default:
                begin
                    e7_thr <= e7_thr;
                end
            endcase
        end
    end

endmodule // fan_table_regs

`default_nettype wire

// File: sim/fan_table_monitor.sv
`timescale 1ns/100ps
`default_nettype none

// ----------------------------------------------------------------
// Port checker
// ----------------------------------------------------------------
module fan_table_monitor #(
    parameter ADDR_W = 10
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [10:0] remote_temp,
    input wire logic [7:0] fan_duty,
    input wire logic table_active
);
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    property p_rdy_pulse;
        pready |=> !pready;
    endproperty
    a_rdy_pulse: assert property (p_rdy_pulse) else $error("pready held past one cycle");

    property p_rdy_setup;
        psel && !penable |=> pready;
    endproperty
    a_rdy_setup: assert property (p_rdy_setup) else $error("no answer after setup");

    property p_rdy_cause;
        pready |-> $past(psel && !penable);
    endproperty
    a_rdy_cause: assert property (p_rdy_cause) else $error("pready without setup");

    property p_rd_upper;
        pready |-> prdata[31:8] == 24'h0;
    endproperty
    a_rd_upper: assert property (p_rd_upper) else $error("upper read bits not zero");

    property p_err_addr;
        psel && !penable && paddr[1:0] != 2'b00 |=> pslverr && prdata == 32'h0;
    endproperty
    a_err_addr: assert property (p_err_addr) else $error("misaligned access not refused");

    property p_err_ready;
        pslverr |-> pready;
    endproperty
    a_err_ready: assert property (p_err_ready) else $error("pslverr outside answer");

    property p_idle_hold;
        !table_active |-> $stable(fan_duty);
    endproperty
    a_idle_hold: assert property (p_idle_hold) else $error("duty moved with no entry hit");

    property p_cold_idle;
        remote_temp[10:2] == 9'h0 |=> !table_active;
    endproperty
    a_cold_idle: assert property (p_cold_idle) else $error("hit below any threshold");
endmodule // fan_table_monitor

bind fan_table_regs fan_table_monitor #(.ADDR_W(ADDR_W)) u_mon (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .remote_temp(remote_temp), .fan_duty(fan_duty),
    .table_active(table_active)
);

`default_nettype wire

// File: sim/tb.sv
`timescale 1ns/100ps
`default_nettype none
`include "fan_table_defines.vh"
`define CHK(nm, ex, got) begin checks_done++; if ((got) !== (ex)) begin err_count++; \
    $display("[FAIL] %s exp %h got %h", nm, ex, got); end end

// ----------------------------------------------------------------
// Register bench
// ----------------------------------------------------------------
module tb;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic [9:0] paddr = 10'h0;
    logic [31:0] pwdata = 32'h0;
    logic [3:0] pstrb = 4'h0;
    logic [10:0] remote_temp = 11'h0;
    wire [31:0] prdata;
    wire pready, pslverr, table_active;
    wire [7:0] fan_duty;
    int err_count = 0, checks_done = 0;
    logic [31:0] rd;
    logic er;
    localparam logic [9:0] A_CTRL = {`IDX_TBL_CTRL, 2'b00};
    localparam logic [9:0] A_OFS = {`IDX_TBL_OFFSET, 2'b00};
    localparam logic [9:0] A_T7 = {`IDX_E7_THR, 2'b00};
    localparam logic [9:0] A_D7 = {`IDX_E7_DUTY, 2'b00};
    localparam logic [9:0] A_T8 = {`IDX_E8_THR, 2'b00};
    localparam logic [9:0] A_D8 = {`IDX_E8_DUTY, 2'b00};
    localparam logic [9:0] A_MODE = {`IDX_TBL_MODE, 2'b00};
    localparam logic [9:0] A_STAT = {`IDX_TBL_STATUS, 2'b00};

    fan_table_regs #(.ADDR_W(10)) dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .remote_temp(remote_temp), .fan_duty(fan_duty),
        .table_active(table_active)
    );

    initial
    begin
        forever #4 pclk = ~pclk;
    end

    task automatic apb(input logic w, input logic [9:0] a, input logic [7:0] d,
                       input logic [3:0] s);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= {24'h0, d};
        pstrb <= s;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1 && n < 20)
        begin
            @(posedge pclk);
            n++;
        end
        if (n >= 20)
            err_count++;
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [9:0] a, input logic [7:0] d);
        apb(1'b1, a, d, 4'h1);
    endtask

    task automatic rc(input logic [9:0] a, input logic [7:0] ex);
        apb(1'b0, a, 8'h00, 4'h0);
        `CHK("rdata", {24'h0, ex}, rd)
        `CHK("pslverr", 1'b0, er)
    endtask

    // Applies a reading and checks the table outputs once settled
    task automatic ot(input logic [10:0] t, input logic ea, input logic [7:0] ed);
        remote_temp <= t;
        repeat (3) @(posedge pclk);
        @(negedge pclk);
        `CHK("table_active", ea, table_active)
        `CHK("fan_duty", ed, fan_duty)
    endtask

    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    initial
    begin
        repeat (5000) @(posedge pclk);
        err_count++;
        report_and_stop();
    end

    initial
    begin
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        rc(A_T7, 8'h7f);
        rc(A_D7, 8'h3f);
        rc(A_T8, 8'h7f);
        rc(A_D8, 8'h3f);
        rc(A_CTRL, 8'h00);
        rc(A_OFS, 8'h00);
        $display("test reset_values done");
        wr(A_T7, 8'ha0);
        rc(A_T7, 8'h7f);
        wr(A_CTRL, 8'hdf);
        wr(A_D7, 8'h00);
        rc(A_D7, 8'h3f);
        wr(A_CTRL, 8'h20);
        wr(A_T7, 8'ha0);
        rc(A_T7, 8'h20);
        apb(1'b1, A_D7, 8'h00, 4'he);
        rc(A_D7, 8'h3f);
        wr(A_D7, 8'hd5);
        rc(A_D7, 8'h15);
        $display("test write_lock done");
        ot(11'd260, 1'b0, 8'h00);
        ot(11'd264, 1'b1, 8'h15);
        wr(A_MODE, 8'h01);
        rc(A_T7, 8'ha0);
        ot(11'd262, 1'b0, 8'h15);
        for (int i = 0; i < 4; i++)
        begin
            wr(A_MODE, 8'(8'h01 | (i << 1)));
            rc(A_D7, i == 3 ? 8'hd5 : 8'h15);
            ot(11'd264, 1'b1, i == 3 ? 8'hd5 : 8'h15);
        end
        $display("test resolution done");
        wr(A_T8, 8'h30);
        wr(A_D8, 8'h2a);
        ot(11'd392, 1'b1, 8'h2a);
        wr(A_OFS, 8'h70);
        ot(11'd392, 1'b0, 8'h2a);
        ot(11'h4b0, 1'b1, 8'hd5);
        ot(11'h508, 1'b1, 8'h2a);
        rc(A_STAT, 8'h03);
        $display("test thresholds done");
        apb(1'b0, 10'h000, 8'h00, 4'h0);
        `CHK("pslverr", 1'b1, er)
        apb(1'b1, 10'h171, 8'h11, 4'h1);
        `CHK("pslverr", 1'b1, er)
        rc(A_T7, 8'ha0);
        $display("test refusals done");
        report_and_stop();
    end
endmodule // tb

`default_nettype wire
